//--- logic/isr_pkg.sv
// Constants, codes and helpers of the instrument status reporting block.
// Assumes a command parser on the same clock drives one-cycle strobes.
package isr_pkg;
   localparam int ERRQ_DEPTH = 8;
   localparam int ERRQ_AW = 3;
   localparam logic [ERRQ_AW:0] ERRQ_FULL = 4'h8;
   localparam logic [ERRQ_AW:0] ERRQ_LAST = 4'h7;
   localparam logic [ERRQ_AW:0] ERRQ_ZERO = 4'h0;
   localparam int OQ_CW = 5;
   localparam logic [OQ_CW-1:0] OQ_FULL = 5'h10;
   localparam logic [OQ_CW-1:0] OQ_ZERO = 5'h00;
   localparam logic [15:0] ENA_MASK = 16'h7FFF;
   localparam int ENA_TOP = 15;
   localparam logic [7:0] SRE_MASK = 8'hBF;
   localparam logic [7:0] STANDARD_EVENT_STATUS_RST = 8'h80;
   localparam logic [7:0] STANDARD_EVENT_STATUS_LIVE = 8'hFD;
   // Status byte bit positions
   localparam int SB_NU0 = 0;
   localparam int SB_NU1 = 1;
   localparam int SB_EE = 2;
   localparam int SB_QUESTIONABLE_SUMMARY_BIT = 3;
   localparam int SB_MAV = 4;
   localparam int SB_ESB = 5;
   localparam int SB_RQS = 6;
   localparam int SB_OPERATION_SUMMARY_BIT = 7;
   // Standard event bit positions
   localparam int SE_OPC = 0;
   localparam int SE_NU = 1;
   localparam int SE_QYE = 2;
   localparam int SE_DDE = 3;
   localparam int SE_EXE = 4;
   localparam int SE_CME = 5;
   localparam int SE_URQ = 6;
   localparam int SE_PON = 7;
   // Register selectors for reads and writes
   localparam logic [3:0] SEL_STB = 4'h0;
   localparam logic [3:0] SEL_ESR = 4'h1;
   localparam logic [3:0] SEL_ESE = 4'h2;
   localparam logic [3:0] SEL_SRE = 4'h3;
   localparam logic [3:0] SEL_QCOND = 4'h4;
   localparam logic [3:0] SEL_QEVT = 4'h5;
   localparam logic [3:0] SEL_QENA = 4'h6;
   localparam logic [3:0] SEL_OCOND = 4'h7;
   localparam logic [3:0] SEL_OEVT = 4'h8;
   localparam logic [3:0] SEL_OENA = 4'h9;
   localparam logic [3:0] SEL_ERR = 4'hA;
   // Signed error codes
   localparam logic signed [15:0] ERR_NONE = 16'h0000;
   localparam logic signed [15:0] ERR_CMD = 16'hFF9C;
   localparam logic signed [15:0] ERR_EXEC = 16'hFF38;
   localparam logic signed [15:0] ERR_CONFLICT = 16'hFF23;
   localparam logic signed [15:0] ERR_RANGE = 16'hFF22;
   localparam logic signed [15:0] ERR_QUEUE_OVFL = 16'hFEA2;
   localparam logic signed [15:0] ERR_Q_INTR = 16'hFE66;
   localparam logic signed [15:0] ERR_Q_UNTERM = 16'hFE5C;
   localparam logic signed [15:0] ERR_Q_DEADLOCK = 16'hFE52;
   // Class bounds: -100, -200, -300, -400, -500
   localparam logic signed [15:0] CLS_CME_TOP = 16'hFF9C;
   localparam logic signed [15:0] CLS_EXE_TOP = 16'hFF38;
   localparam logic signed [15:0] CLS_DDE_TOP = 16'hFED4;
   localparam logic signed [15:0] CLS_QYE_TOP = 16'hFE70;
   localparam logic signed [15:0] CLS_QYE_END = 16'hFE0C;

   function automatic logic summary(input logic [15:0] stat, input logic [15:0] ena);
      summary = |(stat & ena);
   endfunction : summary

   function automatic logic [7:0] err_mask(input logic signed [15:0] code);
      logic [7:0] m;
      m = 8'h00;
      if (code <= CLS_CME_TOP && code > CLS_EXE_TOP) m[SE_CME] = 1'b1;
      if (code <= CLS_EXE_TOP && code > CLS_DDE_TOP) m[SE_EXE] = 1'b1;
      if (code <= CLS_DDE_TOP && code > CLS_QYE_TOP) m[SE_DDE] = 1'b1;
      if (code <= CLS_QYE_TOP && code > CLS_QYE_END) m[SE_QYE] = 1'b1;
      err_mask = m;
   endfunction : err_mask
endpackage : isr_pkg

//--- logic/isr_event_group.sv
// Condition, event and enable registers of one status group.
// Assumes conditions come from logic on the same clock.
`timescale 1ns/1ps
module isr_event_group
   import isr_pkg::*;
(
   input wire logic mclk_i, // Clock
   input wire logic rst_n_i, // Sync reset, low
   input wire logic [15:0] cond_i, // Live conditions
   input wire logic ena_wr_i, // Enable write strobe
   input wire logic [15:0] ena_data_i, // Enable write data
   input wire logic preset_i, // Clear enable
   input wire logic evt_rd_i, // Event read, clears
   input wire logic cls_i, // Clear status
   output logic [15:0] event_o, // Latched events
   output logic [15:0] enable_o, // Enable mask
   output logic summary_o // Group summary
);
   logic [15:0] cond_q;
   logic [15:0] evt_q;
   logic [15:0] ena_q;
   wire [15:0] rise = cond_i & ~cond_q & ENA_MASK;
   wire [15:0] evt_d = ((evt_rd_i | cls_i) ? 16'h0000 : evt_q) | rise;
   wire [15:0] ena_wd = ena_wr_i ? (ena_data_i & ENA_MASK) : ena_q;
   wire [15:0] ena_d = preset_i ? 16'h0000 : ena_wd;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cond_q <= 16'h0000;
         evt_q <= 16'h0000;
         ena_q <= 16'h0000;
      end else begin
         cond_q <= cond_i;
         evt_q <= evt_d;
         ena_q <= ena_d;
      end
   end

   assign event_o = evt_q;
   assign enable_o = ena_q;
   assign summary_o = summary(evt_q, ena_q);

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   chk_event_latch: assert property (|rise |=> ((evt_q & $past(rise)) == $past(rise)))
      else $error("rising condition not latched");
   chk_event_sticky: assert property (
      (!evt_rd_i && !cls_i) |=> ((evt_q & $past(evt_q)) == $past(evt_q)))
      else $error("event bit lost without read");
   chk_enable_top: assert property (!enable_o[ENA_TOP])
      else $error("enable top bit set");
endmodule : isr_event_group

//--- logic/isr_err_queue.sv
// First-in first-out error queue with overflow marker.
// Assumes push, pop and clear are strobes on the same clock.
`timescale 1ns/1ps
module isr_err_queue
   import isr_pkg::*;
(
   input wire logic mclk_i, // Clock
   input wire logic rst_n_i, // Sync reset, low
   input wire logic push_i, // New entry strobe
   input wire logic [15:0] code_i, // Entry code
   input wire logic pop_i, // Remove oldest
   input wire logic clr_i, // Empty the queue
   output logic [15:0] head_o, // Oldest entry or zero
   output logic nonempty_o, // Entries waiting
   output logic full_o // No room left
);
   logic [15:0] mem_q [ERRQ_DEPTH];
   logic [ERRQ_AW-1:0] rd_ptr_q;
   logic [ERRQ_AW-1:0] wr_ptr_q;
   logic [ERRQ_AW:0] cnt_q;
   wire take = push_i & (cnt_q != ERRQ_FULL) & ~clr_i;
   wire give = pop_i & (cnt_q != ERRQ_ZERO) & ~clr_i;
   wire [15:0] wdata = (cnt_q == ERRQ_LAST) ? ERR_QUEUE_OVFL : code_i;

   always_ff @(posedge mclk_i) begin
      if (take) mem_q[wr_ptr_q] <= wdata;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || clr_i) begin
         rd_ptr_q <= '0;
         wr_ptr_q <= '0;
         cnt_q <= ERRQ_ZERO;
      end else begin
         wr_ptr_q <= wr_ptr_q + ERRQ_AW'(take);
         rd_ptr_q <= rd_ptr_q + ERRQ_AW'(give);
         cnt_q <= cnt_q + (ERRQ_AW + 1)'(take) - (ERRQ_AW + 1)'(give);
      end
   end

   assign nonempty_o = (cnt_q != ERRQ_ZERO);
   assign full_o = (cnt_q == ERRQ_FULL);
   assign head_o = nonempty_o ? mem_q[rd_ptr_q] : ERR_NONE;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_first_in;
      take && cnt_q == ERRQ_ZERO && !give;
   endsequence
   chk_fifo_first: assert property (s_first_in |=> head_o == $past(code_i))
      else $error("first entry not at head");
   chk_ovfl_code: assert property (
      (take && cnt_q == ERRQ_LAST) |=> mem_q[$past(wr_ptr_q)] == ERR_QUEUE_OVFL)
      else $error("overflow code not stored");
   chk_full_drop: assert property (
      (full_o && !pop_i && !clr_i) |=> full_o && wr_ptr_q == $past(wr_ptr_q))
      else $error("entry taken while full");
endmodule : isr_err_queue

//--- logic/isr_status_top.sv
// Status byte, standard event register, masks and queue flags.
// Assumes a parser on the same clock issues commands as strobes.
`timescale 1ns/1ps
module isr_status_top
   import isr_pkg::*;
(
   input wire logic mclk_i, // 200 MHz clock
   input wire logic rst_n_i, // Sync reset, low
   input wire logic local_btn_i, // Local key pin
   input wire logic cls_i, // Clear status
   input wire logic preset_i, // Status preset
   input wire logic opc_cmd_i, // Operation complete command
   input wire logic ops_idle_i, // No operation pending
   input wire logic msg_start_i, // New message after terminator
   input wire logic oq_push_i, // Response byte queued
   input wire logic oq_pop_i, // Response byte read
   output logic oq_full_o, // Output queue full
   input wire logic err_push_i, // Error entry strobe
   input wire logic [15:0] err_code_i, // Signed error code
   input wire logic [15:0] questionable_summary_bit_cond_i, // Questionable conditions
   input wire logic wr_req_i, // Register write strobe
   input wire logic [3:0] wr_sel_i, // Write selector
   input wire logic [15:0] wr_data_i, // Write data
   input wire logic rd_req_i, // Register read strobe
   input wire logic [3:0] rd_sel_i, // Read selector
   output logic [15:0] rd_data_o, // Read data
   output logic rd_valid_o, // Read data valid
   output logic [7:0] status_byte_o, // Serial poll byte
   output logic srq_o // Service request line
);
   logic btn_s1_q;
   logic btn_s2_q;
   logic btn_s3_q;
   logic btn_lvl_q;
   logic opc_pend_q;
   logic opc_pend_d;
   logic [7:0] standard_event_status_q;
   logic [7:0] ese_q;
   logic [7:0] sre_q;
   logic [OQ_CW-1:0] oq_cnt_q;
   logic [OQ_CW-1:0] oq_cnt_d;
   logic [7:0] stb_q;
   logic srq_q;
   logic [15:0] rd_data_q;
   logic rd_valid_q;
   logic [15:0] questionable_summary_bit_evt;
   logic [15:0] questionable_summary_bit_ena;
   logic questionable_summary_bit_sum;
   logic [15:0] operation_summary_bit_evt;
   logic [15:0] operation_summary_bit_ena;
   logic operation_summary_bit_sum;
   logic [15:0] errq_head;
   logic errq_busy;

   // Local key: three stages, level moves once two and three agree
   wire btn_lvl_d = (btn_s2_q == btn_s3_q) ? btn_s2_q : btn_lvl_q;
   wire btn_rise = btn_lvl_d & ~btn_lvl_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         btn_s1_q <= 1'b0;
         btn_s2_q <= 1'b0;
         btn_s3_q <= 1'b0;
         btn_lvl_q <= 1'b0;
      end else begin
         btn_s1_q <= local_btn_i;
         btn_s2_q <= btn_s1_q;
         btn_s3_q <= btn_s2_q;
         btn_lvl_q <= btn_lvl_d;
      end
   end

   // Write and read decode
   wire wr_ese = wr_req_i & (wr_sel_i == SEL_ESE);
   wire wr_sre = wr_req_i & (wr_sel_i == SEL_SRE);
   wire wr_qena = wr_req_i & (wr_sel_i == SEL_QENA);
   wire wr_oena = wr_req_i & (wr_sel_i == SEL_OENA);
   wire rd_esr = rd_req_i & (rd_sel_i == SEL_ESR);
   wire rd_qevt = rd_req_i & (rd_sel_i == SEL_QEVT);
   wire rd_oevt = rd_req_i & (rd_sel_i == SEL_OEVT);
   wire rd_err = rd_req_i & (rd_sel_i == SEL_ERR);

   // Operation complete waits for the pipeline to drain
   wire opc_done = opc_pend_q & ops_idle_i;
   always_comb begin
      opc_pend_d = opc_pend_q;
      if (cls_i || opc_done) opc_pend_d = 1'b0;
      if (opc_cmd_i) opc_pend_d = 1'b1;
   end

   // Standard event register: a new event wins over the read clear
   wire [7:0] err_bits = err_push_i ? err_mask(err_code_i) : 8'h00;
   wire [7:0] opc_bit = {7'h00, opc_done} << SE_OPC;
   wire [7:0] urq_bit = {7'h00, btn_rise} << SE_URQ;
   wire [7:0] standard_event_status_set = (err_bits | opc_bit | urq_bit) & STANDARD_EVENT_STATUS_LIVE;
   wire [7:0] standard_event_status_keep = (rd_esr | cls_i) ? 8'h00 : standard_event_status_q;
   wire [7:0] standard_event_status_d = standard_event_status_keep | standard_event_status_set;

   // Output queue occupancy; a new message discards old responses
   wire oq_full = (oq_cnt_q == OQ_FULL);
   wire oq_in = oq_push_i & ~oq_full;
   wire oq_out = oq_pop_i & (oq_cnt_q != OQ_ZERO);
   always_comb begin
      oq_cnt_d = oq_cnt_q + OQ_CW'(oq_in) - OQ_CW'(oq_out);
      if (msg_start_i) oq_cnt_d = OQ_CW'(oq_in);
   end

   // Status byte assembly
   wire output_pending_bit = (oq_cnt_q != OQ_ZERO);
   wire event_summary_bit = summary({8'h00, standard_event_status_q}, {8'h00, ese_q});
   wire [7:0] sb_raw;
   assign sb_raw[SB_NU0] = 1'b0;
   assign sb_raw[SB_NU1] = 1'b0;
   assign sb_raw[SB_EE] = errq_busy;
   assign sb_raw[SB_QUESTIONABLE_SUMMARY_BIT] = questionable_summary_bit_sum;
   assign sb_raw[SB_MAV] = output_pending_bit;
   assign sb_raw[SB_ESB] = event_summary_bit;
   assign sb_raw[SB_RQS] = 1'b0;
   assign sb_raw[SB_OPERATION_SUMMARY_BIT] = operation_summary_bit_sum;
   wire rqs = summary({8'h00, sb_raw}, {8'h00, sre_q & SRE_MASK});
   wire rqs_cause = |(sb_raw & sre_q);
   wire [7:0] sb_now = sb_raw | ({7'h00, rqs} << SB_RQS);

   // Read selection
   wire [15:0] rd_mux =
      (rd_sel_i == SEL_STB) ? {8'h00, stb_q} :
      (rd_sel_i == SEL_ESR) ? {8'h00, standard_event_status_q} :
      (rd_sel_i == SEL_ESE) ? {8'h00, ese_q} :
      (rd_sel_i == SEL_SRE) ? {8'h00, sre_q} :
      (rd_sel_i == SEL_QCOND) ? (questionable_summary_bit_cond_i & ENA_MASK) :
      (rd_sel_i == SEL_QEVT) ? questionable_summary_bit_evt :
      (rd_sel_i == SEL_QENA) ? questionable_summary_bit_ena :
      (rd_sel_i == SEL_OCOND) ? 16'h0000 :
      (rd_sel_i == SEL_OEVT) ? operation_summary_bit_evt :
      (rd_sel_i == SEL_OENA) ? operation_summary_bit_ena :
      (rd_sel_i == SEL_ERR) ? errq_head :
      16'h0000;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         opc_pend_q <= 1'b0;
         standard_event_status_q <= STANDARD_EVENT_STATUS_RST;
         oq_cnt_q <= OQ_ZERO;
      end else begin
         opc_pend_q <= opc_pend_d;
         standard_event_status_q <= standard_event_status_d;
         oq_cnt_q <= oq_cnt_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ese_q <= 8'h00;
         sre_q <= 8'h00;
      end else begin
         if (wr_ese) ese_q <= wr_data_i[7:0];
         if (wr_sre) sre_q <= wr_data_i[7:0] & SRE_MASK;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         stb_q <= 8'h00;
         srq_q <= 1'b0;
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
      end else begin
         stb_q <= sb_now;
         srq_q <= rqs;
         rd_valid_q <= rd_req_i;
         if (rd_req_i) rd_data_q <= rd_mux;
      end
   end

   assign status_byte_o = stb_q;
   assign srq_o = srq_q;
   assign rd_data_o = rd_data_q;
   assign rd_valid_o = rd_valid_q;
   assign oq_full_o = oq_full;

   isr_event_group u_questionable_summary_bit (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .cond_i(questionable_summary_bit_cond_i),
      .ena_wr_i(wr_qena),
      .ena_data_i(wr_data_i),
      .preset_i(preset_i),
      .evt_rd_i(rd_qevt),
      .cls_i(cls_i),
      .event_o(questionable_summary_bit_evt),
      .enable_o(questionable_summary_bit_ena),
      .summary_o(questionable_summary_bit_sum)
   );

   // Operation group: no condition ever feeds it
   isr_event_group u_operation_summary_bit (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .cond_i(16'h0000),
      .ena_wr_i(wr_oena),
      .ena_data_i(wr_data_i),
      .preset_i(preset_i),
      .evt_rd_i(rd_oevt),
      .cls_i(cls_i),
      .event_o(operation_summary_bit_evt),
      .enable_o(operation_summary_bit_ena),
      .summary_o(operation_summary_bit_sum)
   );

   isr_err_queue u_errq (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .push_i(err_push_i),
      .code_i(err_code_i),
      .pop_i(rd_err),
      .clr_i(cls_i),
      .head_o(errq_head),
      .nonempty_o(errq_busy),
      .full_o()
   );

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_esr_read;
      rd_esr && standard_event_status_set == 8'h00;
   endsequence
   sequence s_esr_answer;
      rd_valid_o && rd_data_o[7:0] == $past(standard_event_status_q) && standard_event_status_q == 8'h00;
   endsequence
   sequence s_opc_finish;
      opc_done && !cls_i;
   endsequence
   sequence s_cls_quiet;
      cls_i && standard_event_status_set == 8'h00 && questionable_summary_bit_cond_i == 16'h0000;
   endsequence
   sequence s_all_clear;
      standard_event_status_q == 8'h00 && questionable_summary_bit_evt == 16'h0000 && !errq_busy;
   endsequence

   chk_sb_unused: assert property (stb_q[SB_NU0] == 1'b0 && stb_q[SB_NU1] == 1'b0)
      else $error("unused status bits set");
   chk_ee_bit: assert property (errq_busy |=> stb_q[SB_EE])
      else $error("error queue bit missing");
   chk_questionable_summary_bit_sum: assert property (|(questionable_summary_bit_evt & questionable_summary_bit_ena) |=> stb_q[SB_QUESTIONABLE_SUMMARY_BIT])
      else $error("questionable summary missing");
   chk_mav_bit: assert property (output_pending_bit |=> stb_q[SB_MAV])
      else $error("output pending bit missing");
   chk_esb_bit: assert property ((|(standard_event_status_q & ese_q)) |=> stb_q[SB_ESB])
      else $error("event summary missing");
   chk_rqs_line: assert property (srq_o == stb_q[SB_RQS])
      else $error("request line and bit differ");
   chk_srq_cause: assert property (srq_o == $past(rqs_cause))
      else $error("request without masked cause");
   chk_operation_summary_bit_zero: assert property (operation_summary_bit_evt == 16'h0000 && !stb_q[SB_OPERATION_SUMMARY_BIT])
      else $error("operation group reports");
   chk_stb_query: assert property ((rd_req_i && rd_sel_i == SEL_STB)
      |=> rd_valid_o && rd_data_o == {8'h00, $past(stb_q)})
      else $error("status byte query wrong");
   chk_opc_set: assert property (s_opc_finish |=> standard_event_status_q[SE_OPC])
      else $error("operation done flag not set");
   chk_standard_event_status_nu: assert property (!standard_event_status_q[SE_NU])
      else $error("unused event bit set");
   chk_err_flags: assert property (
      err_push_i |=> (standard_event_status_q & $past(err_bits)) == $past(err_bits))
      else $error("error class flag not set");
   chk_urq_flag: assert property (btn_rise |=> standard_event_status_q[SE_URQ])
      else $error("local key flag not set");
   chk_esr_clear: assert property (s_esr_read |=> s_esr_answer)
      else $error("event register read not cleared");
   chk_ese_write: assert property (wr_ese |=> ese_q == 8'($past(wr_data_i)))
      else $error("event mask write lost");
   chk_msg_clear: assert property ((msg_start_i && !oq_push_i) |=> oq_cnt_q == OQ_ZERO)
      else $error("output queue not cleared");
   chk_err_read: assert property (rd_err |=> rd_data_o == $past(errq_head))
      else $error("error read not oldest entry");

   // Mask writes, clears, event flag causes and read answers
   chk_sre_write: assert property (wr_sre
      |=> sre_q == (8'($past(wr_data_i)) & SRE_MASK))
      else $error("request mask write lost");
   chk_qena_write: assert property ((wr_qena && !preset_i)
      |=> questionable_summary_bit_ena == ($past(wr_data_i) & ENA_MASK))
      else $error("questionable mask write lost");
   chk_oena_write: assert property ((wr_oena && !preset_i)
      |=> operation_summary_bit_ena == ($past(wr_data_i) & ENA_MASK))
      else $error("operation mask write lost");
   chk_preset_masks: assert property (preset_i
      |=> questionable_summary_bit_ena == 16'h0000 && operation_summary_bit_ena == 16'h0000)
      else $error("masks not cleared by preset");
   chk_operation_summary_bit_read: assert property ((rd_sel_i == SEL_OCOND || rd_sel_i == SEL_OEVT)
      && rd_req_i |=> rd_data_o == 16'h0000)
      else $error("operation group read not zero");
   chk_err_empty: assert property ((rd_err && !errq_busy) |=> rd_data_o == ERR_NONE)
      else $error("empty queue read not zero");
   chk_cls_clear: assert property (s_cls_quiet |=> s_all_clear)
      else $error("clear status left state");
   chk_opc_cause: assert property ((!opc_done && !standard_event_status_q[SE_OPC]) |=> !standard_event_status_q[SE_OPC])
      else $error("operation done flag without cause");
   chk_pon_only: assert property (!standard_event_status_q[SE_PON] |=> !standard_event_status_q[SE_PON])
      else $error("power up flag set after reset");
   chk_esr_upper: assert property (rd_esr |=> rd_data_o[15:8] == 8'h00)
      else $error("event register read upper byte set");
   chk_qcond_read: assert property ((rd_req_i && rd_sel_i == SEL_QCOND)
      |=> rd_data_o == ($past(questionable_summary_bit_cond_i) & ENA_MASK))
      else $error("condition read wrong");
   chk_rdv_pulse: assert property (rd_valid_o == $past(rd_req_i))
      else $error("read valid not one cycle after request");
endmodule : isr_status_top

//--- tb/isr_ctrl_model.sv
// Remote controller model: register writes and reads over the strobe port.
// Assumes the device answers a read one cycle after the read edge.
`timescale 1ns/1ps
module isr_ctrl_model (
   input wire logic mclk_i, // Clock
   input wire logic rd_valid_i, // Read data valid
   input wire logic [15:0] rd_data_i, // Read data
   output logic wr_req_o, // Write strobe
   output logic [3:0] wr_sel_o, // Write selector
   output logic [15:0] wr_data_o, // Write data
   output logic rd_req_o, // Read strobe
   output logic [3:0] rd_sel_o // Read selector
);
   initial begin
      wr_req_o = 1'b0;
      wr_sel_o = 4'hF;
      wr_data_o = 16'h0000;
      rd_req_o = 1'b0;
      rd_sel_o = 4'hF;
   end

   task automatic reg_wr(input logic [3:0] sel, input logic [15:0] data);
      @(posedge mclk_i);
      wr_req_o <= 1'b1;
      wr_sel_o <= sel;
      wr_data_o <= data;
      @(posedge mclk_i);
      wr_req_o <= 1'b0;
      wr_data_o <= ~data;
   endtask : reg_wr

   // Each response is taken before the next message goes out
   task automatic reg_rd(input logic [3:0] sel, output logic [15:0] data);
      @(posedge mclk_i);
      rd_req_o <= 1'b1;
      rd_sel_o <= sel;
      @(posedge mclk_i);
      rd_req_o <= 1'b0;
      rd_sel_o <= ~sel;
      #1;
      data = rd_valid_i ? rd_data_i : 16'hXXXX;
   endtask : reg_rd
endmodule : isr_ctrl_model

//--- tb/isr_status_top_test.sv
// Self-checking bench of the status reporting block.
// Assumes the controller model drives the register port.
`timescale 1ns/1ps
module isr_status_top_test;
   import isr_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic local_btn_i = 1'b0, cls_i = 1'b0, preset_i = 1'b0, opc_cmd_i = 1'b0;
   logic ops_idle_i = 1'b0, msg_start_i = 1'b0, oq_push_i = 1'b0, oq_pop_i = 1'b0;
   logic err_push_i = 1'b0;
   logic [15:0] err_code_i = 16'h0000, questionable_summary_bit_cond_i = 16'h0000;
   logic wr_req, rd_req, rd_valid, oq_full, srq;
   logic [3:0] wr_sel, rd_sel;
   logic [15:0] wr_data, rd_data, rv;
   logic [7:0] status_byte, ese;
   logic [15:0] codes [8];
   int mismatches = 0, n_tests = 0, seed = 56, k;

   always #2.5 mclk_i = ~mclk_i;

   isr_status_top isr_status_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .local_btn_i(local_btn_i), .cls_i(cls_i), .preset_i(preset_i), .opc_cmd_i(opc_cmd_i),
      .ops_idle_i(ops_idle_i), .msg_start_i(msg_start_i), .oq_push_i(oq_push_i),
      .oq_pop_i(oq_pop_i), .oq_full_o(oq_full), .err_push_i(err_push_i),
      .err_code_i(err_code_i), .questionable_summary_bit_cond_i(questionable_summary_bit_cond_i), .wr_req_i(wr_req),
      .wr_sel_i(wr_sel), .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_sel_i(rd_sel),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .status_byte_o(status_byte), .srq_o(srq));

   isr_ctrl_model isr_ctrl_model_inst (.mclk_i(mclk_i), .rd_valid_i(rd_valid),
      .rd_data_i(rd_data), .wr_req_o(wr_req), .wr_sel_o(wr_sel), .wr_data_o(wr_data),
      .rd_req_o(rd_req), .rd_sel_o(rd_sel));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic rd(input logic [3:0] sel, input logic [15:0] exp, input string what);
      logic [15:0] d;
      isr_ctrl_model_inst.reg_rd(sel, d);
      chk(d, exp, what);
   endtask : rd

   // Standard event bit for an error code class
   function automatic int class_bit(input logic signed [15:0] c);
      int n;
      n = -c;
      return 6 - n / 100;
   endfunction : class_bit

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : cyc

   task automatic push_err(input logic [15:0] c);
      @(posedge mclk_i);
      err_push_i <= 1'b1;
      err_code_i <= c;
      @(posedge mclk_i);
      err_push_i <= 1'b0;
   endtask : push_err

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   initial begin
      #100000;
      mismatches++;
      results();
   end

   initial begin
      codes = '{ERR_CMD, ERR_EXEC, ERR_CONFLICT, ERR_RANGE, ERR_QUEUE_OVFL,
                ERR_Q_INTR, ERR_Q_UNTERM, ERR_Q_DEADLOCK};
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      cyc(1);
      chk(status_byte, 8'h00, "idle status byte");
      rd(SEL_ESR, 16'h0080, "power up event");
      rd(SEL_ESR, 16'h0000, "event cleared by read");
      rd(SEL_OCOND, 16'h0000, "operation condition");
      rd(SEL_OEVT, 16'h0000, "operation event");
      rd(4'hF, 16'h0000, "unmapped selector");
      isr_ctrl_model_inst.reg_wr(SEL_OENA, 16'hFFFF);
      rd(SEL_OENA, 16'h7FFF, "operation enable");
      isr_ctrl_model_inst.reg_wr(SEL_ESE, 16'h00FF);
      isr_ctrl_model_inst.reg_wr(SEL_SRE, 16'h00FF);
      rd(SEL_ESE, 16'h00FF, "event mask");
      rd(SEL_SRE, 16'h00BF, "request mask");
      // Every error class, then overflow of the error queue
      for (k = 0; k < 8; k++) begin
         push_err(codes[k]);
         cyc(3);
         chk(status_byte, 8'h64, "status byte after error");
         chk(srq, 1'b1, "service request");
         rd(SEL_ESR, 16'h0001 << class_bit(codes[k]), "error class bit");
      end
      push_err(ERR_CMD);
      push_err(ERR_EXEC);
      rd(SEL_STB, 16'h0064, "status byte query");
      for (k = 0; k < 9; k++)
         rd(SEL_ERR, k < 7 ? codes[k] : (k == 7 ? ERR_QUEUE_OVFL : ERR_NONE), "queue");
      rd(SEL_ESR, 16'h0030, "dropped entries still flagged");
      cyc(3);
      chk(status_byte, 8'h00, "empty queue flag");
      chk(srq, 1'b0, "request withdrawn");
      // Operation complete waits for idle
      @(posedge mclk_i);
      opc_cmd_i <= 1'b1;
      @(posedge mclk_i);
      opc_cmd_i <= 1'b0;
      cyc(5);
      rd(SEL_ESR, 16'h0000, "no completion while busy");
      ops_idle_i <= 1'b1;
      cyc(3);
      rd(SEL_ESR, 16'h0001, "completion event");
      // Local key
      local_btn_i <= 1'b1;
      cyc(10);
      local_btn_i <= 1'b0;
      cyc(10);
      rd(SEL_ESR, 16'h0040, "local key event");
      // Output queue fill and message start
      @(posedge mclk_i);
      oq_push_i <= 1'b1;
      repeat (16) @(posedge mclk_i);
      oq_push_i <= 1'b0;
      #1;
      chk(oq_full, 1'b1, "output queue full");
      oq_pop_i <= 1'b1;
      cyc(1);
      oq_pop_i <= 1'b0;
      cyc(1);
      chk(oq_full, 1'b0, "pop frees a slot");
      chk(status_byte[SB_MAV], 1'b1, "message available");
      @(posedge mclk_i);
      msg_start_i <= 1'b1;
      @(posedge mclk_i);
      msg_start_i <= 1'b0;
      cyc(3);
      chk(status_byte[SB_MAV], 1'b0, "queue cleared by message");
      // Questionable group
      isr_ctrl_model_inst.reg_wr(SEL_QENA, 16'hFFFF);
      rd(SEL_QENA, 16'h7FFF, "questionable mask");
      questionable_summary_bit_cond_i <= 16'h0002;
      cyc(3);
      questionable_summary_bit_cond_i <= 16'h0000;
      cyc(3);
      chk(status_byte[SB_QUESTIONABLE_SUMMARY_BIT], 1'b1, "questionable summary");
      rd(SEL_QCOND, 16'h0000, "live condition");
      rd(SEL_QEVT, 16'h0002, "latched event");
      cyc(3);
      chk(status_byte[SB_QUESTIONABLE_SUMMARY_BIT], 1'b0, "summary after read");
      @(posedge mclk_i);
      preset_i <= 1'b1;
      @(posedge mclk_i);
      preset_i <= 1'b0;
      rd(SEL_QENA, 16'h0000, "mask after preset");
      // Random event masks against random error classes
      for (k = 0; k < 12; k++) begin
         ese = $random(seed);
         isr_ctrl_model_inst.reg_wr(SEL_ESE, {8'h00, ese});
         rv = codes[{$random(seed)} % 7];
         push_err(rv);
         cyc(3);
         chk(status_byte[SB_ESB], ese[class_bit(rv)], "event summary");
         rd(SEL_ESR, 16'h0001 << class_bit(rv), "random class bit");
         rd(SEL_ERR, rv, "random queue entry");
      end
      // Clear status empties events and the error queue
      push_err(ERR_RANGE);
      questionable_summary_bit_cond_i <= 16'h0001;
      cyc(3);
      questionable_summary_bit_cond_i <= 16'h0000;
      cls_i <= 1'b1;
      cyc(1);
      cls_i <= 1'b0;
      cyc(3);
      chk(status_byte, 8'h00, "status after clear");
      rd(SEL_ESR, 16'h0000, "event register after clear");
      rd(SEL_QEVT, 16'h0000, "questionable event after clear");
      rd(SEL_ERR, ERR_NONE, "queue after clear");
      results();
   end
endmodule : isr_status_top_test
